// ===== logic/lit_exec_pkg.sv
// Purpose: Constants for the literal/move/multiply execute block
// Assumes: One instruction word presented per four-phase cycle
// Notes: Opcode fields follow the instruction word layout
`default_nettype none
package lit_exec_pkg;
  // Opcode fields
  localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
  localparam logic [7:0] OPC_LOAD_W = 8'h0E;
  localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
  localparam logic [6:0] OPC_STORE_W = 7'h37;
  localparam int ACCESS_BIT = 8;
  // Access bank split: low half to bank 0, high half to top bank
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
  // Reset values
  localparam logic [7:0] BANK_SEL_RESET = 8'h00;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [7:0] PROD_RESET = 8'h00;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LOAD_BANK = 3'b001,
    OP_LOAD_W = 3'b010,
    OP_STORE_W = 3'b011,
    OP_MUL_LIT = 3'b100
  } op_t;
endpackage
`default_nettype wire

// ===== logic/literal_move_multiply_exec.sv
// Purpose: Decode and execute four single-word core instructions
// Assumes: instr_i comes from core logic on clk_sys_i, held over Q1
// Notes: Four clock edges make one instruction cycle (Q1..Q4)
//
// Overview of operation
// RULE1 - Bank literal load writes bank select, no flags
// RULE2 - Working literal load copies literal into W
// RULE3 - Opcode 0x0E decodes working load, flags untouched
// RULE4 - Working load: decode, read, process, write W
// RULE5 - Store opcode 0110111a writes W to file
// RULE6 - Eight-bit file address spans whole 256-byte bank
// RULE7 - Access bit zero overrides bank select
// RULE8 - Opcode 0x0D multiplies W by literal, unsigned
// RULE9 - Product high byte and low byte registers
// RULE10 - Multiply leaves every status flag untouched
// RULE11 - Zero product never sets the zero flag
// RULE12 - Each instruction is one word, one cycle
`default_nettype none
module literal_move_multiply_exec (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Instruction fetch
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  // Architectural registers
  output logic [7:0] bank_select_reg_o,
  output logic [7:0] working_reg_o,
  output logic [7:0] product_high_reg_o,
  output logic [7:0] product_low_reg_o,
  // File register write port
  output logic file_we_o,
  output logic [11:0] file_addr_o,
  output logic [7:0] file_data_o,
  // Phase, completion and status write
  output logic [1:0] phase_o,
  output logic done_o,
  output logic status_we_o
);

  ////////////////////////////////////////////////////////////////////
  // Quarter phase sequencer
  lit_exec_pkg::phase_t phase;
  lit_exec_pkg::phase_t next_phase;

  always_comb begin
    unique case (phase)
      lit_exec_pkg::PH_Q1: next_phase = lit_exec_pkg::PH_Q2;
      lit_exec_pkg::PH_Q2: next_phase = lit_exec_pkg::PH_Q3;
      lit_exec_pkg::PH_Q3: next_phase = lit_exec_pkg::PH_Q4;
      lit_exec_pkg::PH_Q4: next_phase = lit_exec_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase <= lit_exec_pkg::PH_Q1;
    end else begin
      phase <= next_phase; // RULE12
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_o <= 2'h0;
    end else begin
      phase_o <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q1 decode
  lit_exec_pkg::op_t op;
  lit_exec_pkg::op_t next_op;
  logic [15:0] word;

  always_comb begin
    next_op = lit_exec_pkg::OP_NONE;
    if (instr_valid_i) begin
      if (instr_i[15:8] == lit_exec_pkg::OPC_LOAD_BANK) begin
        next_op = lit_exec_pkg::OP_LOAD_BANK; // RULE1
      end else if (instr_i[15:8] == lit_exec_pkg::OPC_LOAD_W) begin
        next_op = lit_exec_pkg::OP_LOAD_W; // RULE3
      end else if (instr_i[15:8] == lit_exec_pkg::OPC_MUL_LIT) begin
        next_op = lit_exec_pkg::OP_MUL_LIT; // RULE8
      end else if (instr_i[15:9] == lit_exec_pkg::OPC_STORE_W) begin
        next_op = lit_exec_pkg::OP_STORE_W; // RULE5
      end
    end
  end

  // Other opcodes fall to OP_NONE: they belong to other units
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op <= lit_exec_pkg::OP_NONE;
      word <= 16'h0000;
    end else if (phase == lit_exec_pkg::PH_Q1) begin
      op <= next_op; // RULE4
      word <= instr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q2 read operand, Q3 process
  logic [7:0] operand;
  logic [15:0] product;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      operand <= 8'h00;
    end else if (phase == lit_exec_pkg::PH_Q2) begin
      operand <= word[7:0]; // RULE4
    end
  end

  // Unsigned 8x8 product; cannot overflow 16 bits
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      product <= 16'h0000;
    end else if (phase == lit_exec_pkg::PH_Q3) begin
      product <= 16'(working_reg_o) * 16'(operand); // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q4 write destinations
  logic q4;
  assign q4 = (phase == lit_exec_pkg::PH_Q4);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank_select_reg_o <= lit_exec_pkg::BANK_SEL_RESET;
    end else if (q4 && op == lit_exec_pkg::OP_LOAD_BANK) begin
      bank_select_reg_o <= operand; // RULE1
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      working_reg_o <= lit_exec_pkg::W_RESET;
    end else if (q4 && op == lit_exec_pkg::OP_LOAD_W) begin
      working_reg_o <= operand; // RULE2 RULE4
    end
  end

  // W is not written by the multiply, so Q3 reads a stable value
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      product_high_reg_o <= lit_exec_pkg::PROD_RESET;
      product_low_reg_o <= lit_exec_pkg::PROD_RESET;
    end else if (q4 && op == lit_exec_pkg::OP_MUL_LIT) begin
      product_high_reg_o <= product[15:8]; // RULE9
      product_low_reg_o <= product[7:0]; // RULE9
    end
  end

  // Bank for the store: access bank splits on the address top bit
  logic [3:0] store_bank;

  always_comb begin
    if (word[lit_exec_pkg::ACCESS_BIT]) begin
      store_bank = bank_select_reg_o[3:0]; // RULE7
    end else if (word[7]) begin
      store_bank = lit_exec_pkg::ACC_HIGH_BANK; // RULE7
    end else begin
      store_bank = lit_exec_pkg::ACC_LOW_BANK; // RULE7
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      file_we_o <= 1'b0;
      file_addr_o <= 12'h000;
      file_data_o <= 8'h00;
    end else begin
      file_we_o <= q4 && op == lit_exec_pkg::OP_STORE_W; // RULE5
      if (q4 && op == lit_exec_pkg::OP_STORE_W) begin
        file_addr_o <= {store_bank, word[7:0]}; // RULE6
        file_data_o <= working_reg_o; // RULE5
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= q4 && op != lit_exec_pkg::OP_NONE; // RULE12
    end
  end

  // None of these instructions touch N, OV, C, DC or Z
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_we_o <= 1'b0;
    end else begin
      status_we_o <= 1'b0; // RULE10 RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_bank_load: assert property ( // RULE1
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (phase == lit_exec_pkg::PH_Q1 && next_op == lit_exec_pkg::OP_LOAD_BANK)
    |-> ##4 bank_select_reg_o == $past(instr_i[7:0], 4)
  ) else $error("bank select not loaded");

  chk_w_load: assert property ( // RULE2
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (phase == lit_exec_pkg::PH_Q1 && next_op == lit_exec_pkg::OP_LOAD_W)
    |-> ##4 working_reg_o == $past(instr_i[7:0], 4)
  ) else $error("working register not loaded");

  chk_w_stable: assert property ( // RULE8
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !(q4 && op == lit_exec_pkg::OP_LOAD_W) |=> $stable(working_reg_o)
  ) else $error("working register changed unexpectedly");

  chk_phase_cycle: assert property ( // RULE4
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    phase == lit_exec_pkg::PH_Q1 |-> ##3 phase == lit_exec_pkg::PH_Q4
  ) else $error("phase sequence broken");

  chk_store_write: assert property ( // RULE5
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    file_we_o |-> file_data_o == working_reg_o
      && $past(op) == lit_exec_pkg::OP_STORE_W
  ) else $error("store wrote wrong data");

  chk_store_addr: assert property ( // RULE6
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    file_we_o |-> file_addr_o[7:0] == $past(word[7:0])
  ) else $error("store address wrong");

  chk_access_bank: assert property ( // RULE7
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    file_we_o && !$past(word[lit_exec_pkg::ACCESS_BIT])
    |-> file_addr_o[11:8] == {4{file_addr_o[7]}}
  ) else $error("access bank not applied");

  chk_product: assert property ( // RULE9
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q4 && op == lit_exec_pkg::OP_MUL_LIT) |=>
      {product_high_reg_o, product_low_reg_o}
        == 16'($past(working_reg_o)) * 16'($past(operand))
  ) else $error("product wrong");

  chk_no_flags: assert property ( // RULE10 RULE11
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    done_o |-> !status_we_o
  ) else $error("status written");

  chk_one_cycle: assert property ( // RULE12
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    done_o |=> !done_o [*3]
  ) else $error("done repeated within one cycle");

  chk_we_pulse: assert property ( // RULE5
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    file_we_o |=> !file_we_o
  ) else $error("file write longer than one cycle");

  chk_we_only_store: assert property ( // RULE5
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !(q4 && op == lit_exec_pkg::OP_STORE_W) |=> !file_we_o
  ) else $error("file write without a store");

  chk_banked_store: assert property ( // RULE7
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    file_we_o && $past(word[lit_exec_pkg::ACCESS_BIT])
    |-> file_addr_o[11:8] == $past(bank_select_reg_o[3:0])
  ) else $error("bank select not applied");

  chk_mul_keeps_w: assert property ( // RULE8
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q4 && op == lit_exec_pkg::OP_MUL_LIT) |=> $stable(working_reg_o)
  ) else $error("multiply altered working register");

  chk_zero_product: assert property ( // RULE11
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q4 && op == lit_exec_pkg::OP_MUL_LIT && product == 16'h0000)
    |=> !status_we_o
  ) else $error("zero product wrote status");

  chk_done_timing: assert property ( // RULE12
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (phase == lit_exec_pkg::PH_Q1 && next_op != lit_exec_pkg::OP_NONE)
    |-> ##4 done_o
  ) else $error("instruction did not finish in one cycle");

  chk_refused_word: assert property ( // RULE12
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (phase == lit_exec_pkg::PH_Q1 && next_op == lit_exec_pkg::OP_NONE)
    |-> ##4 !done_o
  ) else $error("refused word finished");

  chk_bank_stable: assert property ( // RULE1
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !(q4 && op == lit_exec_pkg::OP_LOAD_BANK)
    |=> $stable(bank_select_reg_o)
  ) else $error("bank select changed unexpectedly");

  chk_product_stable: assert property ( // RULE9
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !(q4 && op == lit_exec_pkg::OP_MUL_LIT)
    |=> $stable({product_high_reg_o, product_low_reg_o})
  ) else $error("product changed without a multiply");

endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the literal/move/multiply block
// Assumes: Words are issued when phase_o shows Q1 as the current phase
// Notes: Results are checked three edges after the word is taken
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i;
  logic reset_n_i;
  logic instr_valid_i;
  logic [15:0] instr_i;
  logic [7:0] bank_sel, w, ph, pl, fdata;
  logic [11:0] faddr;
  logic [1:0] phase;
  logic fwe, done, swe;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  literal_move_multiply_exec DUT (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .bank_select_reg_o(bank_sel),
    .working_reg_o(w),
    .product_high_reg_o(ph),
    .product_low_reg_o(pl),
    .file_we_o(fwe),
    .file_addr_o(faddr),
    .file_data_o(fdata),
    .phase_o(phase),
    .done_o(done),
    .status_we_o(swe)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs under a hundred cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Issues one word in Q1, then junk with valid high in Q2 and Q3
  task automatic issue(input logic [15:0] word, input logic vld,
                       input logic exp_done);
    logic [15:0] prev;
    int n;
    n = 0;
    while (phase !== 2'h0 && n < 8) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk({14'h0, phase}, 16'h0000, "not at Q1");
    prev = {bank_sel, w};
    instr_i = word;
    instr_valid_i = vld;
    @(posedge clk_sys_i);
    #1;
    instr_i = 16'h01C3;
    instr_valid_i = 1'b1;
    chk({14'h0, phase}, 16'h0001, "phase Q2");
    @(posedge clk_sys_i);
    #1;
    @(posedge clk_sys_i);
    #1;
    // Valid drops here so the next call never re-drives it in one step
    instr_valid_i = 1'b0;
    chk({bank_sel, w}, prev, "early write");
    chk({15'h0, done}, 16'h0, "done early");
    chk({15'h0, fwe}, 16'h0, "we early");
    @(posedge clk_sys_i);
    #1;
    chk({15'h0, done}, {15'h0, exp_done}, "done");
    chk({15'h0, swe}, 16'h0, "status write");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({bank_sel, w}, 16'h0000, "reset regs");
    chk({14'h0, phase}, 16'h0000, "reset phase");
    chk({ph, pl}, 16'h0000, "reset product");
    chk({15'h0, fwe}, 16'h0, "reset we");
  endtask

  task automatic t_bank();
    issue(16'h01A5, 1'b1, 1'b1);
    chk({8'h0, bank_sel}, 16'h00A5, "bank load");
    chk({15'h0, fwe}, 16'h0, "stray file write");
    issue(16'h0100, 1'b1, 1'b1);
    chk({8'h0, bank_sel}, 16'h0000, "bank zero");
  endtask

  task automatic t_wload();
    logic [7:0] v[3] = '{8'h00, 8'hFF, 8'h5A};
    for (int i = 0; i < 3; i++) begin
      issue({8'h0E, v[i]}, 1'b1, 1'b1);
      chk({8'h0, w}, {8'h0, v[i]}, "w load");
    end
  endtask

  task automatic t_store();
    logic [8:0] op[4] = '{9'h100, 9'h1FF, 9'h07F, 9'h080};
    logic [11:0] ad[4] = '{12'h500, 12'h5FF, 12'h07F, 12'hF80};
    issue(16'h0E4F, 1'b1, 1'b1);
    issue(16'h0105, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      issue({7'h37, op[i]}, 1'b1, 1'b1);
      chk({15'h0, fwe}, 16'h1, "file we");
      chk({4'h0, faddr}, {4'h0, ad[i]}, "file addr");
      chk({8'h0, fdata}, 16'h004F, "file data");
    end
  endtask

  task automatic t_mul();
    logic [7:0] wv[3] = '{8'hE2, 8'h00, 8'hFF};
    logic [7:0] kv[3] = '{8'hC4, 8'h55, 8'hFF};
    for (int i = 0; i < 3; i++) begin
      issue({8'h0E, wv[i]}, 1'b1, 1'b1);
      issue({8'h0D, kv[i]}, 1'b1, 1'b1);
      chk({ph, pl}, 16'(wv[i]) * 16'(kv[i]), "product");
      chk({8'h0, w}, {8'h0, wv[i]}, "w kept");
    end
  endtask

  // Reset in mid-instruction drops the word and clears every register
  task automatic t_midreset();
    instr_i = 16'h0E3C;
    instr_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b0;
    instr_valid_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk({bank_sel, w}, 16'h0000, "mid reset regs");
    chk({ph, pl}, 16'h0000, "mid reset product");
    chk({14'h0, done, fwe}, 16'h0000, "mid reset pulses");
    chk({14'h0, phase}, 16'h0000, "mid reset phase");
    @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    issue(16'h0E3C, 1'b1, 1'b1);
    chk({8'h0, w}, 16'h003C, "w after reset");
  endtask

  // Unknown opcode and an unflagged word must leave everything alone
  task automatic t_refuse();
    logic [15:0] prev;
    prev = {bank_sel, w};
    issue(16'h0255, 1'b1, 1'b0);
    chk({15'h0, fwe}, 16'h0, "refused write");
    issue(16'h0E77, 1'b0, 1'b0);
    chk({bank_sel, w}, prev, "refused word");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    repeat (5) @(posedge clk_sys_i);
    #1;
    t_reset();
    reset_n_i = 1'b1;
    t_bank();
    t_wload();
    t_store();
    t_mul();
    t_midreset();
    t_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
